// ---- hw/dmc_top.sv ----
`timescale 1ns/1ps
module dmc_top (
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	input  wire logic                         read_convert,
	input  wire logic                         chip_sel_b,
	input  wire logic                         chip_en,
	input  wire logic                         byte_addr,
	input  wire logic                         chan_addr_bit0,
	input  wire logic                         chan_addr_bit1,
	input  wire logic                         chan_addr_bit2,
	input  wire logic                         all_chan_deselect,
	input  wire logic                         addr_latch,
	input  wire logic                         cmp_keep,
	output logic                              busy,
	output logic [dmc_pkg::BUS_LANES-1:0]     data_out,
	output logic [dmc_pkg::BUS_LANES-1:0]     data_oe,
	output logic [dmc_pkg::CHAN_COUNT-1:0]    chan_sel,
	output logic                              mux_gnd,
	output logic [dmc_pkg::RES_BITS-1:0]      dac_code,
	input  wire logic [dmc_pkg::ADDR_W-1:0]   avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	output logic [31:0]                       avs_readdata,
	output logic                              avs_waitrequest
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge history

	logic [dmc_pkg::PIN_COUNT-1:0] pins_raw;
	logic [dmc_pkg::PIN_COUNT-1:0] pins;
	logic [dmc_pkg::PIN_COUNT-1:0] pins_prev;

	assign pins_raw = {cmp_keep, addr_latch, all_chan_deselect,
		chan_addr_bit2, chan_addr_bit1, chan_addr_bit0,
		byte_addr, chip_en, chip_sel_b, read_convert};

	dmc_sync #(
		.W (dmc_pkg::PIN_COUNT)
	) u_sync (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in (pins_raw),
		.sync_out (pins)
	);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pins_prev <= '0;
		end else begin
			pins_prev <= pins;
		end
	end

	logic rc_s;
	logic cs_b_s;
	logic ce_s;
	logic ba_s;
	logic go_now;
	logic go_prev;
	logic rc_fall;
	logic latch_fall;
	logic start_req;

	assign rc_s    = pins[dmc_pkg::PIN_RC];
	assign cs_b_s  = pins[dmc_pkg::PIN_CS_B];
	assign ce_s    = pins[dmc_pkg::PIN_CE];
	assign ba_s    = pins[dmc_pkg::PIN_BYTE];
	assign go_now  = ce_s & ~cs_b_s & ~ba_s;
	assign go_prev = pins_prev[dmc_pkg::PIN_CE] & ~pins_prev[dmc_pkg::PIN_CS_B]
		& ~pins_prev[dmc_pkg::PIN_BYTE];
	assign rc_fall = pins_prev[dmc_pkg::PIN_RC] & ~rc_s;
	assign latch_fall = pins_prev[dmc_pkg::PIN_LATCH]
		& ~pins[dmc_pkg::PIN_LATCH];

	// enable high and select low gate every start
	assign start_req = (rc_fall & ce_s & ~cs_b_s)
		| (go_now & ~go_prev);

	////////////////////////////////////////////////////////////////////////
	// multiplexer address latch

	logic [dmc_pkg::CHAN_BITS-1:0] chan_q;
	logic                          desel_q;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			chan_q  <= '0;
			desel_q <= 1'b1;
		end else if (latch_fall) begin
			chan_q  <= pins[dmc_pkg::PIN_CH0 +: dmc_pkg::CHAN_BITS];
			desel_q <= pins[dmc_pkg::PIN_DESEL];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			chan_sel <= '0;
			mux_gnd  <= 1'b1;
		end else if (desel_q) begin
			chan_sel <= '0;
			mux_gnd  <= 1'b1;
		end else begin
			chan_sel <= dmc_pkg::CHAN_COUNT'(1) << chan_q;
			mux_gnd  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer

	dmc_pkg::dmc_state_e state;
	dmc_pkg::dmc_state_e next_state;
	logic [9:0]          count;
	logic [7:0]          sample_cyc;
	logic [3:0]          div_count;
	logic                trial_tick;
	logic                sar_clear;
	logic                sar_done;
	logic [dmc_pkg::RES_BITS-1:0] sar_val;
	logic [dmc_pkg::RES_BITS-1:0] sar_mask;
	logic [dmc_pkg::RES_BITS-1:0] result;
	logic                eoc;
	logic                eoc_set;
	logic                eoc_clr;

	assign sar_clear = (state == dmc_pkg::DMC_IDLE) && start_req;

	always_comb begin
		next_state = state;
		case (state)
			dmc_pkg::DMC_IDLE: begin
				if (start_req) begin
					next_state = dmc_pkg::DMC_DELAY;
				end
			end
			dmc_pkg::DMC_DELAY: begin
				if (count == 10'(dmc_pkg::DLY_CYC - 1)) begin
					next_state = dmc_pkg::DMC_SAMPLE;
				end
			end
			dmc_pkg::DMC_SAMPLE: begin
				if (count >= {2'b00, sample_cyc}) begin
					next_state = dmc_pkg::DMC_TRIAL;
				end
			end
			dmc_pkg::DMC_TRIAL: begin
				if (sar_done) begin
					next_state = dmc_pkg::DMC_HOLD;
				end
			end
			dmc_pkg::DMC_HOLD: begin
				if (count == 10'(dmc_pkg::HOLD_CYC - 1)) begin
					next_state = dmc_pkg::DMC_IDLE;
				end
			end
			default: begin
				next_state = dmc_pkg::DMC_IDLE;
			end
		endcase
	end

	// starts seen outside idle are dropped; nothing leaves a run early
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= dmc_pkg::DMC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else if (next_state != state) begin
			count <= '0;
		end else if (state != dmc_pkg::DMC_IDLE) begin
			count <= count + 10'd1;
		end
	end

	// conversion clock runs only while trials are sequenced
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			div_count  <= '0;
			trial_tick <= 1'b0;
		end else if (state != dmc_pkg::DMC_TRIAL) begin
			div_count  <= '0;
			trial_tick <= 1'b0;
		end else begin
			div_count  <= div_count + 4'd1;
			trial_tick <= (div_count == 4'(dmc_pkg::TRIAL_DIV - 1));
		end
	end

	dmc_sar #(
		.N (dmc_pkg::RES_BITS)
	) u_sar (
		.clock (clock),
		.rst_b (rst_b),
		.clear (sar_clear),
		.step  (trial_tick),
		.keep  (pins[dmc_pkg::PIN_CMP]),
		.sar   (sar_val),
		.mask  (sar_mask),
		.done  (sar_done)
	);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dac_code <= '0;
		end else begin
			dac_code <= sar_val | sar_mask;
		end
	end

	// result register moves only when the last trial is decided
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			result <= '0;
		end else if (state == dmc_pkg::DMC_TRIAL && sar_done) begin
			result <= sar_val;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else if (state == dmc_pkg::DMC_DELAY
			&& next_state == dmc_pkg::DMC_SAMPLE) begin
			busy <= 1'b1;
		end else if (state == dmc_pkg::DMC_HOLD
			&& next_state == dmc_pkg::DMC_IDLE) begin
			busy <= 1'b0;
		end
	end

	assign eoc_set = (state == dmc_pkg::DMC_HOLD)
		&& (next_state == dmc_pkg::DMC_IDLE);

	// a new end of conversion beats a clear in the same cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			eoc <= 1'b0;
		end else if (eoc_set) begin
			eoc <= 1'b1;
		end else if (eoc_clr) begin
			eoc <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tri-state read-out

	logic read_ok;

	assign read_ok = rc_s & ~busy & (state == dmc_pkg::DMC_IDLE)
		& ce_s & ~cs_b_s;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			data_oe  <= '0;
			data_out <= '0;
		end else begin
			data_oe <= {dmc_pkg::BUS_LANES{read_ok}};
			if (!read_ok) begin
				data_out <= '0;
			end else if (ba_s) begin
				data_out <= {{(dmc_pkg::BUS_LANES - dmc_pkg::LSB_PART){1'b0}},
					result[dmc_pkg::LSB_PART-1:0]};
			end else begin
				data_out <= result[dmc_pkg::RES_BITS-1 -: dmc_pkg::MSB_PART];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then a single answer cycle

	logic        req;
	logic        take;
	logic [31:0] next_readdata;

	assign req  = avs_read | avs_write;
	assign take = req & ~avs_waitrequest;
	assign eoc_clr = take & avs_write & (avs_address == dmc_pkg::OFS_STATUS)
		& avs_writedata[dmc_pkg::ST_EOC];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
		end
	end

	always_comb begin
		next_readdata = '0;
		if (avs_address == dmc_pkg::OFS_CTRL) begin
			next_readdata[dmc_pkg::CTRL_SAMP_LO +: 8] = sample_cyc;
		end else if (avs_address == dmc_pkg::OFS_STATUS) begin
			next_readdata[dmc_pkg::ST_BUSY] = busy;
			next_readdata[dmc_pkg::ST_EOC]  = eoc;
			next_readdata[dmc_pkg::ST_CHAN_LO +: dmc_pkg::CHAN_BITS] = chan_q;
			next_readdata[dmc_pkg::ST_DESEL] = desel_q;
		end else if (avs_address == dmc_pkg::OFS_RESULT) begin
			next_readdata[dmc_pkg::RES_BITS-1:0] = result;
		end else begin
			next_readdata = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= '0;
		end else if (avs_read & avs_waitrequest) begin
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sample_cyc <= dmc_pkg::SAMPLE_RST;
		end else if (take && avs_write && avs_address == dmc_pkg::OFS_CTRL) begin
			sample_cyc <= avs_writedata[dmc_pkg::CTRL_SAMP_LO +: 8];
		end
	end

endmodule : dmc_top

// ---- include/dmc_pkg.sv ----
package dmc_pkg;

	localparam int          RES_BITS      = 12;
	localparam int          CHAN_COUNT    = 8;
	localparam int          CHAN_BITS     = 3;
	localparam int          MSB_PART      = 8;
	localparam int          LSB_PART      = 4;
	localparam int          BUS_LANES     = 8;
	localparam int          SYNC_STAGES   = 2;

	localparam int          CLK_MHZ       = 50;
	localparam int          STATUS_DLY_NS = 200;
	localparam int          HOLD_NS       = 500;
	localparam int          CONV_MAX_NS   = 10000;
	localparam int          STATUS_CYC    = (STATUS_DLY_NS * CLK_MHZ) / 1000;
	localparam int          HOLD_CYC      = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int          CONV_MAX_CYC  = (CONV_MAX_NS * CLK_MHZ) / 1000;
	localparam int          PIPE_CYC      = SYNC_STAGES + 2;
	localparam int          DLY_CYC       = STATUS_CYC - PIPE_CYC;
	localparam int          TRIAL_DIV     = 16;
	localparam logic [7:0]  SAMPLE_RST    = 8'h20;

	localparam int          ADDR_W        = 4;
	localparam logic [3:0]  OFS_CTRL      = 4'h0;
	localparam logic [3:0]  OFS_STATUS    = 4'h4;
	localparam logic [3:0]  OFS_RESULT    = 4'h8;
	localparam int          CTRL_SAMP_LO  = 0;
	localparam int          ST_BUSY       = 0;
	localparam int          ST_EOC        = 1;
	localparam int          ST_CHAN_LO    = 4;
	localparam int          ST_DESEL      = 7;

	localparam int          PIN_RC        = 0;
	localparam int          PIN_CS_B      = 1;
	localparam int          PIN_CE        = 2;
	localparam int          PIN_BYTE      = 3;
	localparam int          PIN_CH0       = 4;
	localparam int          PIN_DESEL     = 7;
	localparam int          PIN_LATCH     = 8;
	localparam int          PIN_CMP       = 9;
	localparam int          PIN_COUNT     = 10;

	typedef enum logic [2:0] {
		DMC_IDLE,
		DMC_DELAY,
		DMC_SAMPLE,
		DMC_TRIAL,
		DMC_HOLD
	} dmc_state_e;

endpackage : dmc_pkg

// ---- hw/dmc_sync.sv ----
`timescale 1ns/1ps
module dmc_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage1;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : dmc_sync

// ---- hw/dmc_sar.sv ----
`timescale 1ns/1ps
module dmc_sar #(
	parameter int N = dmc_pkg::RES_BITS
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic         clear,
	input  wire logic         step,
	input  wire logic         keep,
	output logic      [N-1:0] sar,
	output logic      [N-1:0] mask,
	output logic              done
);

	// clear zeroes the register and aims at the top bit
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sar  <= '0;
			mask <= '0;
			done <= 1'b0;
		end else if (clear) begin
			sar  <= '0;
			mask <= {1'b1, {(N-1){1'b0}}};
			done <= 1'b0;
		end else if (step && mask != '0) begin
			if (keep) begin
				sar <= sar | mask;
			end
			mask <= mask >> 1;
			done <= (mask == {{(N-1){1'b0}}, 1'b1});
		end else begin
			done <= 1'b0;
		end
	end

endmodule : dmc_sar

// ---- sim/dmc_afe.sv ----
`timescale 1ns/1ps
module dmc_afe (
	input  wire logic [7:0]  chan_sel,
	input  wire logic        mux_gnd,
	input  wire logic [11:0] dac_code,
	input  wire logic [11:0] level [8],
	output logic             cmp_keep
);
	logic [11:0] vin;

	// comparator on the selected input, ground when deselected
	always_comb begin
		vin = 12'h000;
		for (int i = 0; i < 8; i++) begin
			if (chan_sel[i] && !mux_gnd) begin
				vin = level[i];
			end
		end
		cmp_keep = (vin >= dac_code);
	end
endmodule : dmc_afe

// ---- sim/dmc_checker.sv ----
`timescale 1ns/1ps
module dmc_checker (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        read_convert,
	input wire logic        chip_sel_b,
	input wire logic        chip_en,
	input wire logic        addr_latch,
	input wire logic        busy,
	input wire logic [7:0]  data_out,
	input wire logic [7:0]  data_oe,
	input wire logic [7:0]  chan_sel,
	input wire logic        mux_gnd,
	input wire logic [11:0] dac_code
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	logic [9:0] busy_cnt;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt <= 10'h000;
		end else if (!busy) begin
			busy_cnt <= 10'h000;
		end else if (busy_cnt != 10'h3ff) begin
			busy_cnt <= busy_cnt + 10'h001;
		end
	end

	sequence s_rc_start;
		$fell(read_convert) && chip_en && !chip_sel_b && !busy;
	endsequence
	sequence s_conv_end;
		$fell(busy);
	endsequence

	a_busy_rise: assert property (s_rc_start |-> ##[1:11] busy)
		else $error("busy late");
	a_no_abort: assert property (s_conv_end |-> busy_cnt >= 10'h0c0)
		else $error("conversion cut short");
	a_busy_bound: assert property (busy |-> busy_cnt < 10'h1f4)
		else $error("conversion too long");
	a_sar_clear: assert property ($rose(busy) |-> ##[1:300] dac_code == 12'h800)
		else $error("first trial not from zero");
	a_oe_idle: assert property (data_oe[0] |-> !busy)
		else $error("bus driven while busy");
	a_oe_form: assert property (data_oe == 8'hff
		|| (data_oe == 8'h00 && data_out == 8'h00))
		else $error("bad bus enable");
	a_rc_float: assert property ((!read_convert)[*6] |-> data_oe == 8'h00)
		else $error("bus driven in convert");
	a_cs_float: assert property (chip_sel_b[*6] |-> data_oe == 8'h00)
		else $error("bus driven deselected");
	a_ce_float: assert property ((!chip_en)[*6] |-> data_oe == 8'h00)
		else $error("bus driven disabled");
	a_mux_map: assert property ($onehot0(chan_sel)
		&& (mux_gnd == (chan_sel == 8'h00)))
		else $error("bad channel select");
	a_mux_hold: assert property (($stable(addr_latch))[*6]
		|-> $stable(chan_sel) && $stable(mux_gnd))
		else $error("channel moved");
endmodule : dmc_checker

bind dmc_top dmc_checker u_dmc_checker (
	.clock(clock), .rst_b(rst_b), .read_convert(read_convert),
	.chip_sel_b(chip_sel_b), .chip_en(chip_en), .addr_latch(addr_latch),
	.busy(busy), .data_out(data_out), .data_oe(data_oe),
	.chan_sel(chan_sel), .mux_gnd(mux_gnd), .dac_code(dac_code)
);

// ---- sim/dmc_top_tb.sv ----
`timescale 1ns/1ps
module dmc_top_tb;
	logic        clock, rst_b, rc, cs_b, ce, ba, lat, des, keep, busy, gnd;
	logic        rd, wr, wreq;
	logic [2:0]  ca, c;
	logic [3:0]  adr;
	logic [3:0]  arm [4];
	logic [7:0]  dout, oe, sel;
	logic [11:0] dac, v;
	logic [11:0] lvl [8];
	logic [31:0] wd, rdat, q, e;
	logic [31:0] seed;
	int          n_fail, total_checks, n, len;

	dmc_top u_dmc_top (
		.clock(clock), .rst_b(rst_b), .read_convert(rc), .chip_sel_b(cs_b),
		.chip_en(ce), .byte_addr(ba), .chan_addr_bit0(ca[0]),
		.chan_addr_bit1(ca[1]), .chan_addr_bit2(ca[2]),
		.all_chan_deselect(des), .addr_latch(lat), .cmp_keep(keep),
		.busy(busy), .data_out(dout), .data_oe(oe), .chan_sel(sel),
		.mux_gnd(gnd), .dac_code(dac), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wreq)
	);
	dmc_afe u_dmc_afe (
		.chan_sel(sel), .mux_gnd(gnd), .dac_code(dac), .level(lvl),
		.cmp_keep(keep)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] st_exp(input logic [2:0] ch,
		input logic d, input logic eoc);
		return {24'h0, d, ch, 2'b00, eoc, 1'b0};
	endfunction : st_exp

	// busy cycles: sample window, twelve divided trials plus the tick and
	// done registers, then the hold before busy drops
	function automatic int conv_len(input int s);
		return s + 1 + dmc_pkg::RES_BITS * dmc_pkg::TRIAL_DIV + 2
			+ dmc_pkg::HOLD_CYC;
	endfunction : conv_len

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			n_fail++;
			$display("Error %0t: saw %h expected %h", $time, s, x);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask : cyc

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(n < 20, 1'b1);
	endtask : bus

	// pins packed as read_convert, select, enable, byte address
	task automatic pins(input logic [3:0] p);
		@(posedge clock);
		{rc, cs_b, ce, ba} <= p;
		cyc(6);
	endtask : pins

	task automatic latch_ch(input logic [2:0] a, input logic d);
		@(posedge clock);
		ca <= a;
		des <= d;
		lat <= 1'b1;
		cyc(3);
		lat <= 1'b0;
		cyc(8);
	endtask : latch_ch

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// whole run is under two thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		end_sim();
	end

	initial begin
		seed = 32'h00012f28;
		rst_b = 1'b0;
		{rc, cs_b, ce, ba} = 4'hd;
		{lat, des, ca, rd, wr, adr, wd} = '0;
		arm = '{4'hb, 4'h0, 4'h6, 4'h3};
		for (int i = 0; i < 8; i++) begin
			lvl[i] = 12'(rnd());
		end
		cyc(20);
		chk({busy, oe, sel, gnd, wreq}, {1'b0, 16'h0, 2'b11});
		rst_b <= 1'b1;
		cyc(3);
		bus(1'b0, dmc_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h20);
		bus(1'b1, 4'hc, 32'hffffffff);
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
		$display("test registers done");
		for (int k = 0; k < 9; k++) begin
			latch_ch(k[2:0], k == 8);
			e = (k == 8) ? 32'h0 : 32'h1 << k;
			chk(sel, e);
			ca <= 3'(rnd());
			des <= ~des;
			cyc(8);
			chk({gnd, sel}, {k == 8, e[7:0]});
			bus(1'b0, dmc_pkg::OFS_STATUS, 32'h0);
			chk(q, st_exp(k[2:0], k == 8, 1'b0));
		end
		$display("test mux done");
		// address lines and latch stay put while converting
		for (int m = 0; m < 4; m++) begin
			c = 3'(rnd());
			v = (m == 0) ? 12'hfff : (m == 1) ? 12'h000 : 12'(rnd());
			lvl[c] <= v;
			if (m == 3) begin
				bus(1'b1, dmc_pkg::OFS_CTRL, 32'h10);
			end
			latch_ch(c, 1'b0);
			pins((m == 0) ? 4'hd : 4'h5);
			pins(arm[m]);
			chk(busy, 1'b0);
			@(posedge clock);
			{rc, cs_b, ce, ba} <= (m == 0) ? 4'h3 : 4'h2;
			n = 0;
			do begin
				@(posedge clock);
				n++;
			end while (busy !== 1'b1 && n < 20);
			chk(n <= 11, 1'b1);
			len = 0;
			do begin
				@(posedge clock);
				len++;
				if (m == 2 && len == 5) rc <= 1'b1;
				if (m == 2 && len == 11) rc <= 1'b0;
			end while (busy !== 1'b0 && len < 600);
			e = (m == 3) ? 32'h10 : 32'(dmc_pkg::SAMPLE_RST);
			chk(len, conv_len(e));
			ca <= ~c;
			if (m != 0) begin
				pins(4'ha);
				chk({oe, dout}, {8'hff, v[11:4]});
			end
			pins(4'hb);
			chk({oe, dout}, {12'hff0, v[3:0]});
			bus(1'b0, dmc_pkg::OFS_RESULT, 32'h0);
			chk(q, {20'h0, v});
			bus(1'b0, dmc_pkg::OFS_STATUS, 32'h0);
			chk(q, st_exp(c, 1'b0, 1'b1));
			bus(1'b1, dmc_pkg::OFS_STATUS, 32'h2);
			bus(1'b0, dmc_pkg::OFS_STATUS, 32'h0);
			chk(q, st_exp(c, 1'b0, 1'b0));
			pins(4'h9);
			chk(oe, 8'h00);
			pins(4'he);
			chk({busy, oe}, 9'h000);
			pins(4'hd);
			$display("test conversion %0d done", m);
		end
		end_sim();
	end
endmodule : dmc_top_tb
